/* plmc_link_mode_ctrl.sv */
// Per-port link mode control register bank with strap defaults
// How it works
// - Bit 7 set skips negotiation; speed and duplex then come from bits 6 and 5.
// - Ports 3 and 4 load bit 7 with the inverted negotiation strap level.
// - Forced speed bit 6: one gives 100BT, zero 10BT; resets to one.
// - Duplex bit 5 forces full or half when negotiation off or failed; resets zero.
// - Ports 3 and 4 take duplex default from LED and carrier-sense straps.
// - Bit 4 advertises flow control; resets to one.
// - Bit 3 advertises 100BT full duplex; resets to one.
// - Bit 2 advertises 100BT half duplex.
// - Identical registers at 0x1c, 0x2c, 0x3c, 0x4c; 0x5c reserved.
// - Bits 1 and 0 advertise 10BT full and half duplex; both reset one.
`timescale 1ns/1ps
module plmc_link_mode_ctrl #(
	parameter int NUM_PORTS = plmc_pkg::NUM_PORTS
) (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire plmc_pkg::plmc_req_type        reg_req,
	output logic [plmc_pkg::DATA_W-1:0]        reg_rdata,
	input  wire logic                          port3_neg_strap_pin,
	input  wire logic                          port4_neg_strap_pin,
	input  wire logic                          duplex_strap_led_pin,
	input  wire logic                          duplex_strap_carrier_pin,
	input  wire logic [NUM_PORTS-1:0]          eval_pulse,
	input  wire logic [NUM_PORTS-1:0]          autoneg_failed,
	output plmc_pkg::plmc_mode_type [NUM_PORTS-1:0] port_mode
);

	////////////////////////////////////////////////////////////////////////////
	// Storage and address decode

	// Each port register holds, from the top bit down:
	//   7 negotiation disable, 6 forced 100BT, 5 forced full duplex,
	//   4 flow control, 3 100BT full, 2 100BT half, 1 10BT full, 0 10BT half
	// A write replaces the whole byte; no bit here is read-only or self-clearing,
	// so read data is simply the stored byte

	logic [plmc_pkg::DATA_W-1:0] ctrl_ff [NUM_PORTS];
	logic [plmc_pkg::DATA_W-1:0] rdata_ff;
	logic [NUM_PORTS-1:0]        sel;
	logic [plmc_pkg::DATA_W-1:0] nxt_rdata;

	// One select per port; the reserved slot matches nothing
	always_comb begin
		sel = '0;
		unique case (reg_req.addr)
			plmc_pkg::PORT1_OFFSET: sel[0] = 1'b1;
			plmc_pkg::PORT2_OFFSET: sel[1] = 1'b1;
			plmc_pkg::PORT3_OFFSET: sel[2] = 1'b1;
			plmc_pkg::PORT4_OFFSET: sel[3] = 1'b1;
			default: sel = '0; // 0x5c reserved and holes read zero
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Strap synchronisers: three stages, a level counts once stages 2 and 3 agree

	// Positions of the four straps in the synchroniser word
	localparam int STRAP_W       = 4;
	localparam int STRAP_NEG3    = 0;
	localparam int STRAP_NEG4    = 1;
	localparam int STRAP_LED     = 2;
	localparam int STRAP_CARRIER = 3;
	localparam int LAST_STAGE    = plmc_pkg::SYNC_STAGES - 1;
	localparam int MID_STAGE     = plmc_pkg::SYNC_STAGES - 2;

	logic [STRAP_W-1:0]               strap_sync_ff [plmc_pkg::SYNC_STAGES];
	logic [plmc_pkg::SYNC_STAGES-1:0] strap_fill_ff;
	logic                             strap_done_ff;
	logic                             strap_agree;
	logic                             strap_load;
	logic                             strap_full;
	logic [STRAP_W-1:0]               strap_now;
	logic [STRAP_W-1:0]               pins;
	logic [NUM_PORTS-1:0]             strap_port;
	logic [NUM_PORTS-1:0]             strap_an_dis;

	// Gather the pins; each is an asynchronous level from a pulled strap
	assign pins[STRAP_NEG3]    = port3_neg_strap_pin;
	assign pins[STRAP_NEG4]    = port4_neg_strap_pin;
	assign pins[STRAP_LED]     = duplex_strap_led_pin;
	assign pins[STRAP_CARRIER] = duplex_strap_carrier_pin;

	// Stage 1 feeds only stage 2; the chain clears to zero, which is no strap
	// reading, so the fill marks below say when it holds real samples
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < plmc_pkg::SYNC_STAGES; i++)
				strap_sync_ff[i] <= '0;
		end else begin
			strap_sync_ff[0] <= pins;
			for (int i = 1; i < plmc_pkg::SYNC_STAGES; i++)
				strap_sync_ff[i] <= strap_sync_ff[i-1];
		end
	end

	// One mark per stage, set as the first pin sample walks down the chain
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_fill_ff <= '0;
		end else begin
			strap_fill_ff <= {strap_fill_ff[MID_STAGE:0], 1'b1};
		end
	end

	// A level counts once the last two stages agree on real samples; a strap
	// still settling at release only delays the load by a cycle or two
	assign strap_now   = strap_sync_ff[LAST_STAGE];
	assign strap_agree = strap_sync_ff[MID_STAGE] == strap_sync_ff[LAST_STAGE];
	assign strap_load  = !strap_done_ff && strap_fill_ff[LAST_STAGE] && strap_agree;

	// Straps are caught once per reset; later pin changes are ignored
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_done_ff <= 1'b0;
		end else if (strap_load) begin
			strap_done_ff <= 1'b1;
		end
	end

	// Full duplex only for LED strap low with carrier strap high; every other
	// pairing, the pulled default among them, gives half duplex
	assign strap_full = !strap_now[STRAP_LED] && strap_now[STRAP_CARRIER];

	// Which ports take strap defaults, and the negotiation disable each gets;
	// the bit is the inverse of the pin, so a pulled-up strap keeps negotiation
	always_comb begin
		strap_port   = '0;
		strap_an_dis = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (p == plmc_pkg::STRAP_PORT_A) begin
				strap_port[p]   = 1'b1;
				strap_an_dis[p] = !strap_now[STRAP_NEG3];
			end
			if (p == plmc_pkg::STRAP_PORT_B) begin
				strap_port[p]   = 1'b1;
				strap_an_dis[p] = !strap_now[STRAP_NEG4];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers; strap load beats a write in the same cycle

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int p = 0; p < NUM_PORTS; p++)
				ctrl_ff[p] <= plmc_pkg::CTRL_RESET;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (reg_req.wr && sel[p])
					ctrl_ff[p] <= reg_req.wdata;
				// Strap ports take bits 7 and 5 from the pins, ahead of a write
				if (strap_load && strap_port[p]) begin
					ctrl_ff[p][plmc_pkg::BIT_AN_DIS] <= strap_an_dis[p];
					ctrl_ff[p][plmc_pkg::BIT_DUPLEX] <= strap_full;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the address

	// Registered read data gives the decode a whole cycle; the price is one
	// cycle of latency, so a master holds the address across two edges.
	// Unselected offsets, the reserved one included, read as zero
	always_comb begin
		nxt_rdata = plmc_pkg::READ_ZERO;
		for (int p = 0; p < NUM_PORTS; p++)
			if (sel[p])
				nxt_rdata = ctrl_ff[p];
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			rdata_ff <= plmc_pkg::READ_ZERO;
		else
			rdata_ff <= nxt_rdata;
	end

	assign reg_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// Effective mode per port, refreshed only on that port's evaluation pulse
	// so a link in progress never sees a half-written setting

	plmc_pkg::plmc_mode_type mode_ff [NUM_PORTS];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			// Reset mode mirrors the register reset, the enable being its inverse
			for (int p = 0; p < NUM_PORTS; p++) begin
				mode_ff[p].autoneg_en  <= !plmc_pkg::CTRL_RESET[plmc_pkg::BIT_AN_DIS];
				mode_ff[p].speed_100   <= plmc_pkg::CTRL_RESET[plmc_pkg::BIT_SPEED];
				mode_ff[p].duplex_full <= plmc_pkg::CTRL_RESET[plmc_pkg::BIT_DUPLEX];
				mode_ff[p].adv_fc      <= plmc_pkg::CTRL_RESET[plmc_pkg::BIT_ADV_FC];
				mode_ff[p].adv_100fd   <= plmc_pkg::CTRL_RESET[plmc_pkg::BIT_ADV_100FD];
				mode_ff[p].adv_100hd   <= plmc_pkg::CTRL_RESET[plmc_pkg::BIT_ADV_100HD];
				mode_ff[p].adv_10fd    <= plmc_pkg::CTRL_RESET[plmc_pkg::BIT_ADV_10FD];
				mode_ff[p].adv_10hd    <= plmc_pkg::CTRL_RESET[plmc_pkg::BIT_ADV_10HD];
			end
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (eval_pulse[p]) begin
					mode_ff[p].autoneg_en  <= !ctrl_ff[p][plmc_pkg::BIT_AN_DIS];
					mode_ff[p].speed_100   <= ctrl_ff[p][plmc_pkg::BIT_SPEED];
					mode_ff[p].duplex_full <= ctrl_ff[p][plmc_pkg::BIT_DUPLEX];
					mode_ff[p].adv_fc      <= ctrl_ff[p][plmc_pkg::BIT_ADV_FC];
					mode_ff[p].adv_100fd   <= ctrl_ff[p][plmc_pkg::BIT_ADV_100FD];
					mode_ff[p].adv_100hd   <= ctrl_ff[p][plmc_pkg::BIT_ADV_100HD];
					mode_ff[p].adv_10fd    <= ctrl_ff[p][plmc_pkg::BIT_ADV_10FD];
					mode_ff[p].adv_10hd    <= ctrl_ff[p][plmc_pkg::BIT_ADV_10HD];
				end
			end
		end
	end

	// Forced duplex also covers a failed negotiation, so the PHY reads it as
	// the fallback; autoneg_failed is not used here at all, neither as a qualifier nor stored
	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_out
		assign port_mode[g] = mode_ff[g];
	end

endmodule

/* plmc_pkg.sv */
// Constants and types for the per-port link mode control bank
package plmc_pkg;
	localparam int          NUM_PORTS     = 4;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 8;
	// Register offsets
	localparam logic [7:0]  PORT1_OFFSET  = 8'h1c;
	localparam logic [7:0]  PORT2_OFFSET  = 8'h2c;
	localparam logic [7:0]  PORT3_OFFSET  = 8'h3c;
	localparam logic [7:0]  PORT4_OFFSET  = 8'h4c;
	localparam logic [7:0]  PORT5_RSVD    = 8'h5c;
	// Field positions
	localparam int          BIT_AN_DIS    = 7;
	localparam int          BIT_SPEED     = 6;
	localparam int          BIT_DUPLEX    = 5;
	localparam int          BIT_ADV_FC    = 4;
	localparam int          BIT_ADV_100FD = 3;
	localparam int          BIT_ADV_100HD = 2;
	localparam int          BIT_ADV_10FD  = 1;
	localparam int          BIT_ADV_10HD  = 0;
	// Reset value: negotiation on, 100BT, half duplex, all abilities advertised
	localparam logic [7:0]  CTRL_RESET    = 8'h5f;
	localparam logic [7:0]  READ_ZERO     = 8'h00;
	// Strap sampling: the two port indices that take strap defaults, and synchroniser depth
	localparam int          STRAP_PORT_A  = 2;
	localparam int          STRAP_PORT_B  = 3;
	localparam int          SYNC_STAGES   = 3;

	// Mode presented to one port's PHY
	typedef struct packed {
		logic autoneg_en;
		logic speed_100;
		logic duplex_full;
		logic adv_fc;
		logic adv_100fd;
		logic adv_100hd;
		logic adv_10fd;
		logic adv_10hd;
	} plmc_mode_type;

	// Register access request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              wr;
		logic [DATA_W-1:0] wdata;
	} plmc_req_type;
endpackage

/* plmc_link_mode_ctrl_monitor.sv */
// Assertion checker for the link mode control bank
`timescale 1ns/1ps
module plmc_link_mode_ctrl_monitor #(
	parameter int NUM_PORTS = plmc_pkg::NUM_PORTS
) (
	input wire logic                                clk,
	input wire logic                                sys_rst,
	input wire plmc_pkg::plmc_req_type              reg_req,
	input wire logic [plmc_pkg::DATA_W-1:0]         reg_rdata,
	input wire logic [NUM_PORTS-1:0]                eval_pulse,
	input wire plmc_pkg::plmc_mode_type [NUM_PORTS-1:0] port_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Write strobe to one offset
	sequence s_wr(a);
		reg_req.wr && reg_req.addr == a;
	endsequence
	// A port's mode moves only on its own evaluation pulse
	property p_hold(int i);
		!eval_pulse[i] |=> $stable(port_mode[i]);
	endproperty
	property p_wr_rd;
		logic [7:0] d;
		(s_wr(8'h2c), d = reg_req.wdata) ##1 (reg_req.addr == 8'h2c && !reg_req.wr)
			|=> reg_rdata == d;
	endproperty
	// Bit 7 is inverted into the enable; the rest map straight across
	property p_eval;
		logic [7:0] d;
		(s_wr(8'h1c), d = reg_req.wdata) ##1 (!reg_req.wr) [*2] ##0 eval_pulse[0]
			|=> port_mode[0] == {~d[7], d[6:0]};
	endproperty
	a_reset_values: assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 8'h00
		&& port_mode == {NUM_PORTS{8'hdf}}) else $error("reset values wrong");
	a_rsvd_read: assert property (!(reg_req.addr inside {8'h1c, 8'h2c, 8'h3c, 8'h4c})
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_write_read: assert property (p_wr_rd) else $error("read back differs");
	a_eval_map: assert property (p_eval) else $error("mode mapping wrong");
	a_hold_port1: assert property (p_hold(0)) else $error("port 1 mode moved");
	a_hold_port2: assert property (p_hold(1)) else $error("port 2 mode moved");
	a_hold_port3: assert property (p_hold(2)) else $error("port 3 mode moved");
	a_hold_port4: assert property (p_hold(3)) else $error("port 4 mode moved");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind plmc_link_mode_ctrl plmc_link_mode_ctrl_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (
	.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.eval_pulse(eval_pulse), .port_mode(port_mode));

/* tb_port_link_mode_control.sv */
// Self-checking testbench for the link mode control bank
`timescale 1ns/1ps
module tb_port_link_mode_control;
	logic                               clk;
	logic                               sys_rst;
	plmc_pkg::plmc_req_type             req;
	logic [7:0]                         rdata;
	logic [3:0]                         eval;
	plmc_pkg::plmc_mode_type [3:0]      mode;
	int                                 error_cnt;
	int                                 comparisons;
	logic                               strap_neg3;
	logic                               strap_neg4;
	logic                               strap_led;
	logic                               strap_carrier;
	// Straps are driven so that a reset in mid-run can try other levels
	plmc_link_mode_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata),
		.port3_neg_strap_pin(strap_neg3), .port4_neg_strap_pin(strap_neg4),
		.duplex_strap_led_pin(strap_led), .duplex_strap_carrier_pin(strap_carrier),
		.eval_pulse(eval), .autoneg_failed(4'h0), .port_mode(mode));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk) #1;
		req = '{addr: a, wr: 1'b1, wdata: d};
		@(posedge clk) #1;
		req.wr = 1'b0;
	endtask
	// Read data lags the address by one cycle
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge clk) #1;
		req.addr = a;
		@(posedge clk) #1;
		chk(rdata, exp);
	endtask
	task automatic pulse(int p);
		@(posedge clk) #1;
		eval = 4'h1 << p;
		@(posedge clk) #1;
		eval = 4'h0;
	endtask
	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_defaults;
		rd(8'h1c, 8'h5f);
		rd(8'h2c, 8'h5f);
		rd(8'h3c, 8'hff);
		rd(8'h4c, 8'h7f);
		rd(8'h5c, 8'h00);
		rd(8'h1d, 8'h00);
		for (int i = 0; i < 4; i++) chk(mode[i], 8'hdf);
	endtask
	// Settings reach a port only on its own evaluation
	task automatic t_modes;
		wr(8'h1c, 8'ha0);
		pulse(0);
		chk(mode[0], 8'h20);
		chk(mode[1], 8'hdf);
		wr(8'h2c, 8'h55);
		rd(8'h2c, 8'h55);
		wr(8'h5c, 8'hff);
		rd(8'h5c, 8'h00);
		rd(8'h1c, 8'ha0);
		pulse(1);
		chk(mode[1], 8'hd5);
		pulse(2);
		chk(mode[2], 8'h7f);
		chk(mode[3], 8'hdf);
		wr(8'h4c, 8'h83);
		pulse(3);
		chk(mode[3], 8'h03);
	endtask
	// A further reset with other strap levels; earlier writes must vanish
	task automatic t_straps(logic n3, logic n4, logic led, logic car,
		logic [7:0] exp3, logic [7:0] exp4);
		@(posedge clk) #1;
		sys_rst = 1'b1;
		strap_neg3 = n3;
		strap_neg4 = n4;
		strap_led = led;
		strap_carrier = car;
		repeat (16) @(posedge clk);
		#1;
		chk(rdata, 8'h00);
		for (int i = 0; i < 4; i++) chk(mode[i], 8'hdf);
		sys_rst = 1'b0;
		repeat (4) @(posedge clk);
		rd(8'h1c, 8'h5f);
		rd(8'h2c, 8'h5f);
		rd(8'h3c, exp3);
		rd(8'h4c, exp4);
	endtask
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		strap_neg3 = 1'b0;
		strap_neg4 = 1'b1;
		strap_led = 1'b0;
		strap_carrier = 1'b1;
		req = '0;
		eval = 4'h0;
		error_cnt = 0;
		comparisons = 0;
		repeat (16) @(posedge clk);
		#1 sys_rst = 1'b0;
		repeat (4) @(posedge clk);
		t_defaults();
		t_modes();
		t_straps(1'b1, 1'b0, 1'b1, 1'b0, 8'h5f, 8'hdf);
		t_straps(1'b0, 1'b1, 1'b1, 1'b1, 8'hdf, 8'h5f);
		end_sim();
	end
endmodule
